// file: verilog/psi_consts.vh
`ifndef PSI_CONSTS_VH
`define PSI_CONSTS_VH
// command payload: 4-bit code, 13-bit address, 5-bit instr, 4-bit scratch data = 26 bits
`define PSI_CODE_W 4
`define PSI_ADDR_W 13
`define PSI_INS_W 5
`define PSI_AF_W 11
`define PSI_SD_W 4
`define PSI_PAY_W 26
`define PSI_FRAME_W 52
// function mode codes
`define PSI_CMD_NOP 4'h0
`define PSI_CMD_STOP 4'h1
`define PSI_CMD_RUN 4'h2
`define PSI_CMD_HOLD 4'h3
`define PSI_CMD_RELEASE 4'h4
`define PSI_CMD_SLOW_ON 4'h5
`define PSI_CMD_SLOW_OFF 4'h6
`define PSI_CMD_PM_WRITE 4'h7
`define PSI_CMD_SP_WRITE 4'h8
`define PSI_CMD_SP_READ 4'h9
`define PSI_CMD_MONITOR 4'hA
// reply frame: 4 scratch data, 5 instr, 11 addr field, 2 page, 1 result, 2 phase = 25 bits
`define PSI_REPLY_W 25
// access step numbers in sys_clk cycles
`define PSI_SETUP_CYC 4'h2
`define PSI_STROBE_CYC 4'h4
`define PSI_STROBE_END 4'h6
`define PSI_DONE_CYC 4'h8
// give-up count while waiting for the stop confirmation
`define PSI_STOP_WAIT 8'hFF
`endif

// file: verilog/psi_interface.v
`timescale 1ns/100ps
`include "psi_consts.vh"
// Summary of operation
// - every action is chosen by a four-bit function code from the programmer
// - code and data come true then inverted; receiver checks both copies agree
// - data moves bit-serially, one line each direction
// - link clock times every bit in both directions
// - ready asserted only while interface can take part in a transfer
// - monitor five-bit instruction bus as program memory data
// - monitor eleven-bit address-field bus as program memory data
// - accept the two phase-control inputs
// - stop request high commands processor halt in update phase
// - stopped input high confirms halt in update phase
// - hold output low stops processor in processing phase
// - slow-down issued only while programmer is attached
// - address bus enable low and address lines driven only in update phase
// - instruction and address-field outputs tri-stated unless word bus enable low
// - address-field outputs carry program word field or scratchpad address
// - program memory write high stores presented word
// - scratch write prep low only in update phase
// - scratch data lines bidirectional, direction set by write prep
// - scratch write pulse latches scratch data into scratchpad
module psi_interface #(
  parameter CODE_W = `PSI_CODE_W,
  parameter ADDR_W = `PSI_ADDR_W
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire link_clock_i,
  input wire link_data_from_programmer_i,
  input wire transfer_req_i,
  input wire stop_permit_i,
  output reg link_data_to_programmer_o,
  output wire ready_o,
  input wire [4:0] instr_field_in_i,
  input wire [10:0] addr_field_in_i,
  input wire [1:0] page_bits_i,
  input wire [1:0] phase_ctrl_i,
  input wire result_bit_i,
  input wire store_cmd_i,
  input wire cpu_stopped_i,
  output reg cpu_stop_request_o,
  output reg hold_n_o,
  output reg cpu_slow_down_o,
  input wire [12:0] prog_mem_addr_i,
  output reg [12:0] prog_mem_addr_o,
  output wire [12:0] prog_mem_addr_oe_o,
  output reg addr_bus_drive_en_n_o,
  output reg word_bus_drive_en_n_o,
  output reg [4:0] instr_field_out_o,
  output wire [4:0] instr_field_out_oe_o,
  output reg [10:0] addr_field_out_o,
  output wire [10:0] addr_field_out_oe_o,
  input wire [3:0] scratch_data_i,
  output reg [3:0] scratch_data_o,
  output wire [3:0] scratch_data_oe_o,
  output reg scratch_write_prep_n_o,
  output reg scratch_write_pulse_o,
  output reg prog_mem_write_o,
  output reg cmd_error_o
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RECV = 3'd1;
  localparam ST_EXEC = 3'd2;
  localparam ST_WAIT_STOP = 3'd3;
  localparam ST_ACCESS = 3'd4;
  localparam ST_REPLY = 3'd5;
  localparam ST_RELEASE = 3'd6;
  localparam PAY_W = `PSI_PAY_W;
  localparam FRAME_W = `PSI_FRAME_W;
  localparam REPLY_W = `PSI_REPLY_W;

  // two-flop synchronisers for all pins from the isolated link
  reg [1:0] clk_sync;
  reg [1:0] din_sync;
  reg [1:0] req_sync;
  reg [1:0] perm_sync;
  reg [1:0] stopped_sync;
  reg clk_prev;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      clk_sync <= 2'h0;
      din_sync <= 2'h0;
      req_sync <= 2'h0;
      perm_sync <= 2'h0;
      stopped_sync <= 2'h0;
      clk_prev <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], link_clock_i};
      din_sync <= {din_sync[0], link_data_from_programmer_i};
      req_sync <= {req_sync[0], transfer_req_i};
      perm_sync <= {perm_sync[0], stop_permit_i};
      stopped_sync <= {stopped_sync[0], cpu_stopped_i};
      // edge history taken from the second stage only, never the first
      clk_prev <= clk_sync[1];
    end
  end
  wire clk_rise = clk_sync[1] & ~clk_prev;
  wire clk_fall = ~clk_sync[1] & clk_prev;
  wire req = req_sync[1];
  wire permit = perm_sync[1];
  wire stopped = stopped_sync[1];

  reg [2:0] state;
  reg [FRAME_W-1:0] shift;
  reg [5:0] bit_cnt;
  reg [REPLY_W-1:0] reply;
  reg [3:0] step;
  reg [CODE_W-1:0] code;
  reg [ADDR_W-1:0] addr;
  reg [4:0] word_ins;
  reg [3:0] word_sd;
  reg held_stop;
  reg reply_armed;
  reg [7:0] wait_cnt;

  // frame: payload true first, then payload inverted
  wire [PAY_W-1:0] pay_true = shift[FRAME_W-1:PAY_W];
  wire [PAY_W-1:0] pay_inv = shift[PAY_W-1:0];
  // one flipped line bit breaks the pair, so noise never reaches the buses
  wire frame_ok = (pay_true == ~pay_inv);
  // captured status snapshot returned to programmer
  wire [REPLY_W-1:0] snapshot = {scratch_data_i, instr_field_in_i, addr_field_in_i,
                                 page_bits_i, result_bit_i, phase_ctrl_i};

  // busy while halting so a second command cannot land mid-access
  assign ready_o = (state == ST_IDLE) | (state == ST_RECV) | (state == ST_REPLY);
  assign prog_mem_addr_oe_o = {ADDR_W{~addr_bus_drive_en_n_o}};
  assign instr_field_out_oe_o = {5{~word_bus_drive_en_n_o}};
  assign addr_field_out_oe_o = {11{~word_bus_drive_en_n_o}};
  assign scratch_data_oe_o = {4{~scratch_write_prep_n_o}};

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      shift <= {FRAME_W{1'b0}};
      bit_cnt <= 6'h0;
      reply <= {REPLY_W{1'b0}};
      step <= 4'h0;
      code <= 4'h0;
      addr <= 13'h0;
      word_ins <= 5'h0;
      word_sd <= 4'h0;
      held_stop <= 1'b0;
      reply_armed <= 1'b0;
      wait_cnt <= 8'h00;
      link_data_to_programmer_o <= 1'b0;
      cpu_stop_request_o <= 1'b0;
      hold_n_o <= 1'b1;
      cpu_slow_down_o <= 1'b0;
      prog_mem_addr_o <= 13'h0;
      addr_bus_drive_en_n_o <= 1'b1;
      word_bus_drive_en_n_o <= 1'b1;
      instr_field_out_o <= 5'h0;
      addr_field_out_o <= 11'h0;
      scratch_data_o <= 4'h0;
      scratch_write_prep_n_o <= 1'b1;
      scratch_write_pulse_o <= 1'b0;
      prog_mem_write_o <= 1'b0;
      cmd_error_o <= 1'b0;
    end else begin
      // programmer gone: withdraw stop and hold
      if (!permit) begin
        cpu_stop_request_o <= 1'b0;
        hold_n_o <= 1'b1;
      end
      // attachment is judged by request activity; no sense pin exists
      if (!req && state == ST_IDLE)
        cpu_slow_down_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          bit_cnt <= 6'h0;
          if (req)
            state <= ST_RECV;
        end
        ST_RECV: begin
          if (!req) begin
            // request dropped mid-frame: partial frame discarded
            state <= ST_IDLE;
          end else if (clk_rise) begin
            shift <= {shift[FRAME_W-2:0], din_sync[1]};
            if (bit_cnt == FRAME_W - 1)
              state <= ST_EXEC;
            bit_cnt <= bit_cnt + 6'h1;
          end
        end
        ST_EXEC: begin
          cmd_error_o <= ~frame_ok;
          {code, addr, word_ins, word_sd} <= pay_true;
          // status frozen here so the reply shows one instant, save the scratch data a scratch read fetches later
          reply <= snapshot;
          reply_armed <= 1'b0;
          state <= ST_REPLY;
          bit_cnt <= 6'h0;
          if (frame_ok) begin
            case (pay_true[PAY_W-1:PAY_W-CODE_W])
              `PSI_CMD_STOP: begin
                if (permit)
                  cpu_stop_request_o <= 1'b1;
              end
              `PSI_CMD_RUN: cpu_stop_request_o <= 1'b0;
              `PSI_CMD_HOLD: begin
                if (permit)
                  hold_n_o <= 1'b0;
              end
              `PSI_CMD_RELEASE: hold_n_o <= 1'b1;
              `PSI_CMD_SLOW_ON: cpu_slow_down_o <= 1'b1;
              `PSI_CMD_SLOW_OFF: cpu_slow_down_o <= 1'b0;
              `PSI_CMD_PM_WRITE, `PSI_CMD_SP_WRITE, `PSI_CMD_SP_READ: begin
                if (permit) begin
                  // halt first; access waits for the stop confirmation
                  held_stop <= cpu_stop_request_o;
                  cpu_stop_request_o <= 1'b1;
                  step <= 4'h0;
                  wait_cnt <= 8'h00;
                  state <= ST_WAIT_STOP;
                end
              end
              default: ;
            endcase
          end
        end
        ST_WAIT_STOP: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (!permit)
            state <= ST_RELEASE;
          else if (stopped) begin
            step <= 4'h0;
            state <= ST_ACCESS;
          end else if (wait_cnt == `PSI_STOP_WAIT) begin
            // processor never confirmed: give up with the buses untouched
            state <= ST_RELEASE;
          end
        end
        ST_ACCESS: begin
          step <= step + 4'h1;
          if (step == 4'h0) begin
            addr_bus_drive_en_n_o <= 1'b0;
            word_bus_drive_en_n_o <= 1'b0;
            prog_mem_addr_o <= addr;
            instr_field_out_o <= word_ins;
            addr_field_out_o <= addr[10:0];
            // scratchpad cycles leave the program address bus as input
            if (code != `PSI_CMD_PM_WRITE)
              addr_bus_drive_en_n_o <= 1'b1;
            if (code == `PSI_CMD_SP_WRITE) begin
              scratch_data_o <= word_sd;
              scratch_write_prep_n_o <= 1'b0;
            end
          end
          // strobe sits mid-window so address and data have settled
          if (step == `PSI_STROBE_CYC) begin
            if (code == `PSI_CMD_PM_WRITE)
              prog_mem_write_o <= 1'b1;
            if (code == `PSI_CMD_SP_WRITE)
              scratch_write_pulse_o <= 1'b1;
            if (code == `PSI_CMD_SP_READ)
              reply[REPLY_W-1:REPLY_W-4] <= scratch_data_i;
          end
          if (step == `PSI_STROBE_END) begin
            prog_mem_write_o <= 1'b0;
            scratch_write_pulse_o <= 1'b0;
          end
          if (step == `PSI_DONE_CYC) begin
            // release buses before letting the processor run
            addr_bus_drive_en_n_o <= 1'b1;
            word_bus_drive_en_n_o <= 1'b1;
            scratch_write_prep_n_o <= 1'b1;
            state <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // hand back whatever halt state the programmer had set before
          cpu_stop_request_o <= held_stop & permit;
          reply_armed <= 1'b0;
          state <= ST_REPLY;
          bit_cnt <= 6'h0;
        end
        ST_REPLY: begin
          // msb stands before the first rise; the frame's own last fall must not shift it
          link_data_to_programmer_o <= reply[REPLY_W-1];
          if (clk_rise)
            reply_armed <= 1'b1;
          if (clk_fall && reply_armed) begin
            reply <= {reply[REPLY_W-2:0], 1'b0};
            bit_cnt <= bit_cnt + 6'h1;
          end
          // a new frame needs the request to drop and rise again
          if (!req)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // psi_interface

// file: dv/psi_properties.sv
`timescale 1ns/100ps
module psi_properties (
  input wire sys_clk_i,
  input wire rst_i,
  input wire stop_permit_i,
  input wire cpu_stopped_i,
  input wire ready_o,
  input wire cpu_stop_request_o,
  input wire hold_n_o,
  input wire [12:0] prog_mem_addr_oe_o,
  input wire addr_bus_drive_en_n_o,
  input wire word_bus_drive_en_n_o,
  input wire [4:0] instr_field_out_oe_o,
  input wire [10:0] addr_field_out_oe_o,
  input wire [3:0] scratch_data_oe_o,
  input wire scratch_write_prep_n_o,
  input wire scratch_write_pulse_o,
  input wire prog_mem_write_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pulse2(sig);
    sig [*2] ##1 !sig;
  endsequence
  property p_addr_oe; prog_mem_addr_oe_o == {13{~addr_bus_drive_en_n_o}}; endproperty
  a_addr_oe: assert property (p_addr_oe) else $error("address bus direction wrong");
  property p_word_oe; {instr_field_out_oe_o, addr_field_out_oe_o} == {16{~word_bus_drive_en_n_o}}; endproperty
  a_word_oe: assert property (p_word_oe) else $error("word bus not three-stated");
  property p_sd_oe; scratch_data_oe_o == {4{~scratch_write_prep_n_o}}; endproperty
  a_sd_oe: assert property (p_sd_oe) else $error("scratch data direction wrong");
  property p_pmw_bus; prog_mem_write_o |-> !word_bus_drive_en_n_o && !addr_bus_drive_en_n_o; endproperty
  a_pmw_bus: assert property (p_pmw_bus) else $error("write without buses driven");
  property p_pmw_len; $rose(prog_mem_write_o) |-> s_pulse2(prog_mem_write_o); endproperty
  a_pmw_len: assert property (p_pmw_len) else $error("program write strobe width");
  property p_wps_len; $rose(scratch_write_pulse_o) |-> s_pulse2(scratch_write_pulse_o); endproperty
  a_wps_len: assert property (p_wps_len) else $error("scratch write pulse width");
  property p_wps_prep; scratch_write_pulse_o |-> !scratch_write_prep_n_o && addr_bus_drive_en_n_o; endproperty
  a_wps_prep: assert property (p_wps_prep) else $error("scratch pulse without prepare");
  property p_word_len; $fell(word_bus_drive_en_n_o) |-> !word_bus_drive_en_n_o [*8] ##1 word_bus_drive_en_n_o;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word bus window length");
  property p_access; $fell(word_bus_drive_en_n_o) |-> cpu_stop_request_o && cpu_stopped_i && !ready_o; endproperty
  a_access: assert property (p_access) else $error("access before halt confirmed");
  property p_permit; $rose(cpu_stop_request_o) || $fell(hold_n_o) |-> $past(stop_permit_i); endproperty
  a_permit: assert property (p_permit) else $error("stop without permit");
endmodule // psi_properties
bind psi_interface psi_properties u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stop_permit_i(stop_permit_i),
  .cpu_stopped_i(cpu_stopped_i), .ready_o(ready_o), .cpu_stop_request_o(cpu_stop_request_o), .hold_n_o(hold_n_o),
  .prog_mem_addr_oe_o(prog_mem_addr_oe_o), .addr_bus_drive_en_n_o(addr_bus_drive_en_n_o),
  .word_bus_drive_en_n_o(word_bus_drive_en_n_o), .instr_field_out_oe_o(instr_field_out_oe_o),
  .addr_field_out_oe_o(addr_field_out_oe_o), .scratch_data_oe_o(scratch_data_oe_o),
  .scratch_write_prep_n_o(scratch_write_prep_n_o), .scratch_write_pulse_o(scratch_write_pulse_o),
  .prog_mem_write_o(prog_mem_write_o));

// file: dv/psi_cpu_model.sv
`timescale 1ns/100ps
module psi_cpu_model (
  input wire sys_clk_i,
  input wire slow_i,
  input wire cpu_stop_request_i,
  input wire prog_mem_write_i,
  input wire scratch_write_pulse_i,
  input wire [12:0] prog_mem_addr_i,
  input wire [4:0] instr_field_i,
  input wire [10:0] addr_field_i,
  input wire [3:0] scratch_data_i,
  output reg cpu_stopped_o,
  output wire [3:0] scratch_rd_o,
  output reg [17:0] pm_word_o
);
  reg [7:0] dly_sh = 8'h00;
  reg [3:0] sp_mem [0:15];
  integer i;
  initial begin
    for (i = 0; i < 16; i = i + 1) sp_mem[i] = 4'h3;
    cpu_stopped_o = 1'b0;
    pm_word_o = 18'h00000;
  end
  always @(posedge sys_clk_i) begin
    dly_sh <= {dly_sh[6:0], cpu_stop_request_i};
    // slow mode confirms late; halt drops with the request
    cpu_stopped_o <= cpu_stop_request_i & (slow_i ? dly_sh[6] : dly_sh[0]);
    if (prog_mem_write_i) pm_word_o <= {prog_mem_addr_i, instr_field_i};
    if (scratch_write_pulse_i) sp_mem[addr_field_i[3:0]] <= scratch_data_i;
  end
  assign scratch_rd_o = sp_mem[addr_field_i[3:0]];
endmodule // psi_cpu_model

// file: dv/psi_interface_tb.sv
`timescale 1ns/100ps
`include "psi_consts.vh"
module psi_interface_tb;
  reg sys_clk_i = 1'b0, rst_i = 1'b1, link_clock_i = 1'b0, link_data_from_programmer_i = 1'b0, slow = 1'b0;
  reg transfer_req_i = 1'b0, stop_permit_i = 1'b0, result_bit_i = 1'h1, store_cmd_i = 1'b0;
  reg [4:0] instr_field_in_i = 5'h0B;
  reg [10:0] addr_field_in_i = 11'h5A3;
  reg [1:0] page_bits_i = 2'h2, phase_ctrl_i = 2'h1;
  wire link_data_to_programmer_o, ready_o, cpu_stop_request_o, hold_n_o, cpu_slow_down_o, cpu_stopped_i, cmd_error_o;
  wire addr_bus_drive_en_n_o, word_bus_drive_en_n_o, scratch_write_prep_n_o, scratch_write_pulse_o, prog_mem_write_o;
  wire [12:0] prog_mem_addr_o, prog_mem_addr_oe_o, prog_mem_addr_i;
  wire [4:0] instr_field_out_o, instr_field_out_oe_o;
  wire [10:0] addr_field_out_o, addr_field_out_oe_o;
  wire [3:0] scratch_data_o, scratch_data_oe_o, scratch_data_i, sp_rd;
  wire [17:0] pm_word;
  reg [24:0] rep;
  reg [2:0] st;
  integer fails = 0, n_tests = 0, i;
  // nothing else drives the address pins, so they read back what the block puts out
  assign prog_mem_addr_i = prog_mem_addr_oe_o & prog_mem_addr_o;
  assign scratch_data_i = (scratch_data_oe_o & scratch_data_o) | (~scratch_data_oe_o & sp_rd);
  psi_interface DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clock_i(link_clock_i),
    .link_data_from_programmer_i(link_data_from_programmer_i), .transfer_req_i(transfer_req_i),
    .stop_permit_i(stop_permit_i), .link_data_to_programmer_o(link_data_to_programmer_o), .ready_o(ready_o),
    .instr_field_in_i(instr_field_in_i), .addr_field_in_i(addr_field_in_i), .page_bits_i(page_bits_i),
    .phase_ctrl_i(phase_ctrl_i), .result_bit_i(result_bit_i), .store_cmd_i(store_cmd_i),
    .cpu_stopped_i(cpu_stopped_i), .cpu_stop_request_o(cpu_stop_request_o), .hold_n_o(hold_n_o),
    .cpu_slow_down_o(cpu_slow_down_o), .prog_mem_addr_i(prog_mem_addr_i), .prog_mem_addr_o(prog_mem_addr_o),
    .prog_mem_addr_oe_o(prog_mem_addr_oe_o), .addr_bus_drive_en_n_o(addr_bus_drive_en_n_o),
    .word_bus_drive_en_n_o(word_bus_drive_en_n_o), .instr_field_out_o(instr_field_out_o),
    .instr_field_out_oe_o(instr_field_out_oe_o), .addr_field_out_o(addr_field_out_o),
    .addr_field_out_oe_o(addr_field_out_oe_o), .scratch_data_i(scratch_data_i), .scratch_data_o(scratch_data_o),
    .scratch_data_oe_o(scratch_data_oe_o), .scratch_write_prep_n_o(scratch_write_prep_n_o),
    .scratch_write_pulse_o(scratch_write_pulse_o), .prog_mem_write_o(prog_mem_write_o), .cmd_error_o(cmd_error_o));
  psi_cpu_model u_cpu (.sys_clk_i(sys_clk_i), .slow_i(slow), .cpu_stop_request_i(cpu_stop_request_o),
    .prog_mem_write_i(prog_mem_write_o), .scratch_write_pulse_i(scratch_write_pulse_o),
    .prog_mem_addr_i(prog_mem_addr_o), .instr_field_i(instr_field_out_o), .addr_field_i(addr_field_out_o),
    .scratch_data_i(scratch_data_o), .cpu_stopped_o(cpu_stopped_i), .scratch_rd_o(sp_rd), .pm_word_o(pm_word));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (fails == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task half;
    repeat (4) @(negedge sys_clk_i);
  endtask
  task xfer(input [3:0] code, input [12:0] addr, input [4:0] instr_field_in, input [3:0] sd, input bad);
    reg [51:0] frm;
    integer k;
    begin
      frm = {code, addr, instr_field_in, sd, ~{code, addr, instr_field_in, sd} ^ {25'h0, bad}};
      transfer_req_i = 1'b1;
      half;
      for (k = 51; k >= 0; k = k - 1) begin
        link_data_from_programmer_i = frm[k];
        half;
        link_clock_i = 1'b1;
        half;
        link_clock_i = 1'b0;
      end
      k = 0;
      repeat (8) @(negedge sys_clk_i);
      while (ready_o !== 1'b1) begin
        k = k + 1;
        if (k > 400) begin
          fails = fails + 1;
          end_sim;
        end
        @(negedge sys_clk_i);
      end
      for (k = 0; k < 25; k = k + 1) begin
        half;
        rep = {rep[23:0], link_data_to_programmer_o};
        link_clock_i = 1'b1;
        half;
        link_clock_i = 1'b0;
      end
      st = {cpu_stop_request_o, hold_n_o, cpu_slow_down_o};
      transfer_req_i = 1'b0;
      half;
      half;
    end
  endtask
  localparam [48:0] TBL = {`PSI_CMD_STOP, 3'h6, `PSI_CMD_RUN, 3'h2, `PSI_CMD_HOLD, 3'h0, `PSI_CMD_RELEASE, 3'h2,
    `PSI_CMD_NOP, 3'h2, `PSI_CMD_SLOW_OFF, 3'h2, `PSI_CMD_SLOW_ON, 3'h3};
  initial begin
    repeat (10) @(negedge sys_clk_i);
    chk({hold_n_o, addr_bus_drive_en_n_o, word_bus_drive_en_n_o, scratch_write_prep_n_o, cpu_stop_request_o,
      cpu_slow_down_o, prog_mem_write_o, scratch_write_pulse_o, cmd_error_o}, 32'h1E0);
    rst_i = 1'b0;
    stop_permit_i = 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      xfer(TBL[48-7*i -: 4], 13'h0000, 5'h00, 4'h0, 1'b0);
      chk(st, TBL[44-7*i -: 3]);
    end
    chk(cpu_slow_down_o, 32'h0);
    xfer(`PSI_CMD_HOLD, 13'h0000, 5'h00, 4'h0, 1'b1);
    chk({cmd_error_o, st}, 32'hA);
    stop_permit_i = 1'b0;
    xfer(`PSI_CMD_STOP, 13'h0000, 5'h00, 4'h0, 1'b0);
    chk({cmd_error_o, st}, 32'h2);
    stop_permit_i = 1'b1;
    xfer(`PSI_CMD_MONITOR, 13'h0000, 5'h00, 4'h0, 1'b0);
    chk(rep[20:0], {5'h0B, 11'h5A3, 2'h2, 1'h1, 2'h1});
    slow = 1'b1;
    xfer(`PSI_CMD_PM_WRITE, 13'h1ABC, 5'h15, 4'h0, 1'b0);
    chk(pm_word, {13'h1ABC, 5'h15});
    xfer(`PSI_CMD_SP_WRITE, 13'h0005, 5'h00, 4'hA, 1'b0);
    xfer(`PSI_CMD_SP_READ, 13'h0005, 5'h00, 4'h0, 1'b0);
    chk(rep[24:21], 32'hA);
    slow = 1'b0;
    xfer(`PSI_CMD_SP_READ, 13'h0006, 5'h00, 4'h0, 1'b0);
    chk(rep[24:21], 32'h3);
    end_sim;
  end
endmodule // psi_interface_tb
